// >>> dv/clp_meas_model.sv
// Purpose: stands in for the phase measurement and the blocking matrix
// Assumes: the bench commands levels on the rising edge of clk_in
// Notes: phase 2 may take its own level so that one phase disagrees
`timescale 1ns/1ps
module clp_meas_model (
  input wire logic clk_in,
  input wire logic [clp_pkg::CW-1:0] lvl_in,
  input wire logic [clp_pkg::CW-1:0] odd_in,
  input wire logic blk_req_in,
  output logic [clp_pkg::CW-1:0] cur_l1_out,
  output logic [clp_pkg::CW-1:0] cur_l2_out,
  output logic [clp_pkg::CW-1:0] cur_l3_out,
  output logic block_out
);
  import clp_pkg::*;
  // magnitudes refresh one clock after a command, like a filter stage
  always_ff @(posedge clk_in) begin
    cur_l1_out <= lvl_in;
    cur_l2_out <= odd_in;
    cur_l3_out <= lvl_in;
  end
  // blocking matrix: requests are raised a program cycle ahead of any delay
  always_ff @(posedge clk_in) begin
    block_out <= blk_req_in;
  end
endmodule

// >>> dv/test_cold_load_pickup_detector.sv
// Purpose: self-checking bench of the cold load pick-up detector
// Assumes: CYC_PER_MS is 4, so one program cycle is 20 clocks
// Notes: stimulus changes midway between ticks so checks have slack
`timescale 1ns/1ps
module test_cold_load_pickup_detector;
  import clp_pkg::*;
  localparam int TK = 20;
  localparam logic [CW-1:0] LO = 16'h0032;
  localparam logic [CW-1:0] MID = 16'h00C8;
  localparam logic [CW-1:0] INR = 16'h0190;
  localparam logic [CW-1:0] OVR = 16'h02BC;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [CW-1:0] lvl = MID;
  logic [CW-1:0] odd = MID;
  logic blk_req = 1'b0;
  logic [TW-1:0] t_start = 19'h00003;
  logic [TW-1:0] t_max = 19'h00004;
  logic [TW-1:0] t_min = 19'h00002;
  logic [NEV-1:0] off_sel = 6'h2F;
  logic [NEV-1:0] on_sel = 6'h3F;
  logic cnt_clear = 1'b0;
  logic [LPW-1:0] log_idx = 4'h0;
  logic [CW-1:0] cur1, cur2, cur3, log_i1;
  logic block, active, blocked, log_valid;
  logic [NEV-1:0] ev_on, ev_off;
  logic [NEV-1:0] on_seen = 6'h00;
  logic [NEV-1:0] off_seen = 6'h00;
  logic [15:0] act_count, blk_count;
  logic [LPW-1:0] log_count;
  logic [2:0] log_event;
  logic [GW-1:0] log_group;
  logic [CW-1:0] log_i2, log_i3;
  logic [TW-1:0] log_to_act, log_act_time, log_startup, log_reclaim;
  logic [SW-1:0] ev_time, log_time;
  logic [SW-1:0] act_stamp = '0;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exp_act = 0;

  // 125 MHz clock
  always #4 clk_in = ~clk_in;

  clp_meas_model meas_u (
    .clk_in(clk_in), .lvl_in(lvl), .odd_in(odd), .blk_req_in(blk_req),
    .cur_l1_out(cur1), .cur_l2_out(cur2), .cur_l3_out(cur3), .block_out(block)
  );

  clp_top #(.CYC_PER_MS(4)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .cur_l1_in(cur1), .cur_l2_in(cur2), .cur_l3_in(cur3),
    .thr_low_in(16'h0064), .thr_inrush_in(16'h012C), .thr_over_in(16'h0258),
    .t_start_in(t_start), .t_max_in(t_max), .t_min_in(t_min),
    .block_in(block), .group_in(3'h5),
    .ev_on_sel_in(on_sel), .ev_off_sel_in(off_sel),
    .cnt_clear_in(cnt_clear), .log_idx_in(log_idx),
    .cold_load_active_out(active), .blocked_out(blocked),
    .cold_load_event_block_on_out(ev_on), .cold_load_event_block_off_out(ev_off),
    .ev_time_out(ev_time), .act_count_out(act_count), .blk_count_out(blk_count),
    .log_count_out(log_count), .log_valid_out(log_valid), .log_time_out(log_time),
    .log_event_out(log_event), .log_i1_out(log_i1), .log_i2_out(log_i2),
    .log_i3_out(log_i3), .log_to_act_out(log_to_act), .log_act_time_out(log_act_time),
    .log_startup_out(log_startup), .log_reclaim_out(log_reclaim),
    .log_group_out(log_group)
  );

  // collect every event pulse seen since reset
  always @(posedge clk_in) begin
    if (rst_n_in) begin
      on_seen <= on_seen | ev_on;
      off_seen <= off_seen | ev_off;
      if (ev_on[EV_ACT]) begin
        act_stamp <= ev_time;
      end
    end
  end

  // cut a hung run short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("ERROR at %0t ns: run did not finish in time", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk_in);
  endtask

  // set phases 1 and 3 to a, phase 2 to b, then let n program cycles pass
  task automatic drive(input logic [CW-1:0] a, input logic [CW-1:0] b, input int n);
    lvl <= a;
    odd <= b;
    ticks(n);
  endtask

  task automatic activate();
    drive(LO, LO, 3);
    exp_act++;
    chk(active, 1);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (TK / 2) @(posedge clk_in);
    chk(active, 0);
    chk(act_count, 0);
    chk(log_count, 0);
    $display("test reset done");
    drive(LO, MID, 5);
    chk(active, 0);
    drive(LO, LO, 2);
    drive(MID, MID, 3);
    chk(active, 0);
    $display("test no pick-up done");
    drive(LO, LO, 2);
    chk(active, 0);
    ticks(1);
    exp_act++;
    chk(active, 1);
    chk(act_count, exp_act);
    chk(log_count, 1);
    chk(log_event, EV_ACT);
    chk(log_i1, LO);
    chk(log_group, 3'h5);
    chk(log_i2, LO);
    chk(log_i3, LO);
    // one cycle was still to go, no active or start-up time yet, full reclaim left
    chk(log_to_act, 1);
    chk(log_act_time, 0);
    chk(log_startup, 0);
    chk(log_reclaim, t_min);
    // first activation falls on program cycle 13, stamped in ms since reset
    chk(log_time, 13 * TICK_MS);
    chk(act_stamp, 13 * TICK_MS);
    drive(MID, MID, 1);
    chk(active, 1);
    ticks(1);
    chk(active, 0);
    $display("test minimum time done");
    activate();
    drive(INR, INR, 1);
    chk(active, 1);
    blk_req <= 1'b1;
    repeat (3) @(posedge clk_in);
    blk_req <= 1'b0;
    repeat (TK - 3) @(posedge clk_in);
    chk(active, 1);
    ticks(1);
    chk(active, 1);
    ticks(1);
    chk(active, 0);
    drive(MID, MID, 2);
    $display("test maximum time done");
    activate();
    drive(INR, INR, 2);
    chk(active, 1);
    drive(MID, MID, 1);
    chk(active, 0);
    activate();
    drive(INR, OVR, 1);
    chk(active, 0);
    drive(MID, MID, 1);
    activate();
    drive(INR, MID, 2);
    chk(active, 0);
    drive(MID, MID, 1);
    $display("test release paths done");
    blk_req <= 1'b1;
    drive(LO, LO, 4);
    chk(blocked, 1);
    chk(active, 0);
    chk(blk_count, 1);
    chk(log_event, EV_BLK);
    blk_req <= 1'b0;
    drive(MID, MID, 2);
    chk(blocked, 0);
    activate();
    drive(INR, INR, 1);
    blk_req <= 1'b1;
    ticks(1);
    chk(active, 0);
    blk_req <= 1'b0;
    drive(MID, MID, 2);
    $display("test blocking done");
    t_start <= 19'h00000;
    drive(LO, LO, 1);
    exp_act++;
    chk(active, 1);
    drive(MID, MID, 2);
    chk(active, 0);
    t_start <= 19'h00003;
    drive(16'h0063, 16'h0063, 1);
    drive(16'h0066, 16'h0066, 2);
    exp_act++;
    chk(active, 1);
    drive(MID, MID, 2);
    chk(active, 0);
    $display("test start timer done");
    t_start <= 19'h00000;
    for (int i = 0; i < LOG_DEPTH; i++) begin
      drive(LO, LO, 1);
      drive(MID, MID, 2);
      exp_act++;
    end
    chk(log_count, LOG_DEPTH);
    chk(act_count, exp_act);
    log_idx <= LOG_LAST;
    repeat (2) @(posedge clk_in);
    chk(log_valid, 1);
    chk(log_event, EV_ACT);
    log_idx <= 4'hC;
    repeat (2) @(posedge clk_in);
    chk(log_valid, 0);
    cnt_clear <= 1'b1;
    @(posedge clk_in);
    cnt_clear <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(act_count, 0);
    chk(blk_count, 0);
    chk(on_seen, 6'h3F);
    chk(off_seen, 6'h2F);
    $display("test log and counters done");
    end_sim();
  end
endmodule

// >>> src/clp_cmp.sv
// Purpose: one phase against one threshold, resetting at 97 % (above) or 100/97 (below) of threshold
// Assumes: current and threshold share one scale
// Notes: updates only on the program-cycle tick
`timescale 1ns/1ps
module clp_cmp #(
  parameter int CW = 16,
  parameter bit ABOVE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic [CW-1:0] cur_in,
  input wire logic [CW-1:0] thr_in,
  output logic hit_out
);
  import clp_pkg::*;
  logic [CW+6:0] cur_f, cur_h, thr_f, thr_h;
  logic next_hit;

  // scaled values so that 97 % needs no divider
  always_comb begin
    cur_f = (CW+7)'(cur_in) * (CW+7)'(PCT_FULL);
    cur_h = (CW+7)'(cur_in) * (CW+7)'(HYS_PCT);
    thr_f = (CW+7)'(thr_in) * (CW+7)'(PCT_FULL);
    thr_h = (CW+7)'(thr_in) * (CW+7)'(HYS_PCT);
    next_hit = hit_out;
    if (tick_in) begin
      if (ABOVE) begin
        next_hit = hit_out ? (cur_f > thr_h) : (cur_in > thr_in);
      end else begin
        next_hit = hit_out ? (cur_h <= thr_f) : (cur_in < thr_in);
      end
    end
  end

  // hit register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hit_out <= 1'b0;
    end else begin
      hit_out <= next_hit;
    end
  end
endmodule

// >>> src/clp_pkg.sv
// Purpose: shared constants and types of the cold load pick-up detector
// Assumes: 125 MHz system clock, 5 ms program cycle
// Notes: timer settings and counts are in program-cycle ticks
package clp_pkg;
  // clock and program cycle
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int MSW = 17;
  localparam int TICK_MS = 5;
  localparam logic [2:0] TICK_LAST = 3'(TICK_MS - 1);
  // blocking must arrive this long before a delay expires (far side)
  localparam int BLK_LEAD_MS = 5;
  localparam int BLK_LEAD_TICKS = (BLK_LEAD_MS + TICK_MS - 1) / TICK_MS;
  // widths
  localparam int CW = 16;
  localparam int TW = 19;
  localparam int GW = 3;
  // timer defaults, in ms and in ticks
  localparam int TSET_MS = 10000;
  localparam int TMAX_MS = 30000;
  localparam int TMIN_MS = 40;
  localparam logic [TW-1:0] TSET_DEF = TW'(TSET_MS / TICK_MS);
  localparam logic [TW-1:0] TMAX_DEF = TW'(TMAX_MS / TICK_MS);
  localparam logic [TW-1:0] TMIN_DEF = TW'(TMIN_MS / TICK_MS);
  // comparator hysteresis in percent of setting
  localparam int HYS_PCT = 97;
  localparam int PCT_FULL = 100;
  // event indices
  localparam int NEV = 6;
  localparam int EV_LOW = 0;
  localparam int EV_INR = 1;
  localparam int EV_NRM = 2;
  localparam int EV_OVR = 3;
  localparam int EV_ACT = 4;
  localparam int EV_BLK = 5;
  // operation log
  localparam int LOG_DEPTH = 12;
  localparam int LPW = 4;
  localparam logic [LPW-1:0] LOG_LAST = LPW'(LOG_DEPTH - 1);
  localparam int SW = 32;
  typedef enum logic [1:0] {ST_NORM, ST_ACT, ST_BLK} clp_state_t;
  typedef struct packed {
    logic [SW-1:0] stamp;
    logic [2:0] event_id;
    logic [CW-1:0] i1;
    logic [CW-1:0] i2;
    logic [CW-1:0] i3;
    logic [TW-1:0] to_act;
    logic [TW-1:0] act_time;
    logic [TW-1:0] startup;
    logic [TW-1:0] reclaim;
    logic [GW-1:0] group;
  } clp_rec_t;
endpackage

// >>> src/clp_top.sv
// Purpose: cold load pick-up detector with timers, events, counters and log
// Assumes: phase currents come from logic on clk_in; block_in may be async
// Notes: one program cycle is TICK_MS ms; timers count those ticks
`timescale 1ns/1ps
// Functional notes
// - blocking sampled once per program cycle
// - pick-up unblocked asserts active, timers run
// - pick-up while blocked gives blocked indication only
// - blocking during active drops output, release path
// - start timer, 5 ms steps, 10 s default
// - maximum timer, 30 s default, limits inrush
// - minimum timer, 40 ms default, also reclaim
// - activate after low current for start time
// - inrush while active runs maximum timer
// - back between thresholds ends start-up
// - nonzero minimum time prolongs active output
// - low ends early: no activation; zero immediate
// - overcurrent while active releases at once
// - inrush until maximum expiry releases output
// - no inrush once minimum time since activation is done releases output
// - inrush in minimum: hold until max or done
// - time-stamped selectable ON/OFF events, six kinds
// - clearable counters of activations and blocks
// - circular log of twelve newest ON records
// - record: time, event, currents, timers, group
// - low means all three phases below
// - inrush means all three phases above
// - overcurrent means any phase above
// - inrush and over comparators reset at 97 % of setting, low ones at 100/97 of setting
module clp_top #(
  parameter int CYC_PER_MS = clp_pkg::CYC_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [clp_pkg::CW-1:0] cur_l1_in,
  input wire logic [clp_pkg::CW-1:0] cur_l2_in,
  input wire logic [clp_pkg::CW-1:0] cur_l3_in,
  input wire logic [clp_pkg::CW-1:0] thr_low_in,
  input wire logic [clp_pkg::CW-1:0] thr_inrush_in,
  input wire logic [clp_pkg::CW-1:0] thr_over_in,
  input wire logic [clp_pkg::TW-1:0] t_start_in,
  input wire logic [clp_pkg::TW-1:0] t_max_in,
  input wire logic [clp_pkg::TW-1:0] t_min_in,
  input wire logic block_in,
  input wire logic [clp_pkg::GW-1:0] group_in,
  input wire logic [clp_pkg::NEV-1:0] ev_on_sel_in,
  input wire logic [clp_pkg::NEV-1:0] ev_off_sel_in,
  input wire logic cnt_clear_in,
  input wire logic [clp_pkg::LPW-1:0] log_idx_in,
  output logic cold_load_active_out,
  output logic blocked_out,
  output logic [clp_pkg::NEV-1:0] cold_load_event_block_on_out,
  output logic [clp_pkg::NEV-1:0] cold_load_event_block_off_out,
  output logic [clp_pkg::SW-1:0] ev_time_out,
  output logic [15:0] act_count_out,
  output logic [15:0] blk_count_out,
  output logic [clp_pkg::LPW-1:0] log_count_out,
  output logic log_valid_out,
  output logic [clp_pkg::SW-1:0] log_time_out,
  output logic [2:0] log_event_out,
  output logic [clp_pkg::CW-1:0] log_i1_out,
  output logic [clp_pkg::CW-1:0] log_i2_out,
  output logic [clp_pkg::CW-1:0] log_i3_out,
  output logic [clp_pkg::TW-1:0] log_to_act_out,
  output logic [clp_pkg::TW-1:0] log_act_time_out,
  output logic [clp_pkg::TW-1:0] log_startup_out,
  output logic [clp_pkg::TW-1:0] log_reclaim_out,
  output logic [clp_pkg::GW-1:0] log_group_out
);
  import clp_pkg::*;
  // saturating tick counter step
  function automatic logic [TW-1:0] inc(input logic [TW-1:0] v);
    return (&v) ? v : TW'(v + 1'b1);
  endfunction
  logic [MSW-1:0] ms_cnt, next_ms_cnt;
  logic [2:0] sub_cnt, next_sub_cnt;
  logic [SW-1:0] ms_time, next_ms_time;
  logic ms_en, tick, next_tick, tick_d;
  logic blk_m, blk_q, blk_s, next_blk_s;
  logic [CW-1:0] cur1, cur2, cur3, next_cur1, next_cur2, next_cur3;
  logic [2:0] low_hit, inr_hit, ovr_hit;
  logic low, inr, ovr, nrm;
  clp_state_t state, next_state;
  logic [TW-1:0] low_cnt, min_cnt, max_cnt;
  logic [TW-1:0] next_low_cnt, next_min_cnt, next_max_cnt;
  logic [TW-1:0] low_inc, min_inc, max_inc;
  logic fire_act, fire_blk, next_act, next_blkd;
  logic [NEV-1:0] lv, lv_prev, next_ev_on, next_ev_off;
  logic [15:0] next_act_cnt, next_blk_cnt;
  clp_rec_t log_mem [LOG_DEPTH];
  clp_rec_t wr_rec, rd_rec, next_rd_rec;
  logic [LPW-1:0] wr_ptr, next_wr_ptr, next_log_cnt;
  logic [LPW:0] rd_sum;
  logic [LPW-1:0] rd_idx;
  logic next_log_valid;
  // millisecond divider, timestamp and program-cycle tick
  always_comb begin
    ms_en = (ms_cnt == MSW'(CYC_PER_MS - 1));
    next_ms_cnt = ms_en ? '0 : MSW'(ms_cnt + 1'b1);
    next_ms_time = ms_en ? SW'(ms_time + 1'b1) : ms_time;
    next_sub_cnt = sub_cnt;
    next_tick = 1'b0;
    if (ms_en) begin
      next_tick = (sub_cnt == TICK_LAST);
      next_sub_cnt = next_tick ? 3'h0 : 3'(sub_cnt + 1'b1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ms_cnt <= '0;
      sub_cnt <= 3'h0;
      ms_time <= '0;
      tick <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      ms_cnt <= next_ms_cnt;
      sub_cnt <= next_sub_cnt;
      ms_time <= next_ms_time;
      tick <= next_tick;
      tick_d <= tick;
    end
  end
  // blocking synchroniser and per-cycle sample of block and currents
  always_comb begin
    next_blk_s = tick ? blk_q : blk_s;
    next_cur1 = tick ? cur_l1_in : cur1;
    next_cur2 = tick ? cur_l2_in : cur2;
    next_cur3 = tick ? cur_l3_in : cur3;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      blk_m <= 1'b0;
      blk_q <= 1'b0;
      blk_s <= 1'b0;
      cur1 <= '0;
      cur2 <= '0;
      cur3 <= '0;
    end else begin
      blk_m <= block_in;
      blk_q <= blk_m;
      blk_s <= next_blk_s;
      cur1 <= next_cur1;
      cur2 <= next_cur2;
      cur3 <= next_cur3;
    end
  end
  // nine comparators: three phases against three thresholds
  for (genvar p = 0; p < 3; p++) begin : g_ph
    logic [CW-1:0] cur_p;
    assign cur_p = (p == 0) ? cur_l1_in : ((p == 1) ? cur_l2_in : cur_l3_in);
    clp_cmp #(.CW(CW), .ABOVE(1'b0)) u_low (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cur_in(cur_p), .thr_in(thr_low_in), .hit_out(low_hit[p]));
    clp_cmp #(.CW(CW), .ABOVE(1'b1)) u_inr (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cur_in(cur_p), .thr_in(thr_inrush_in), .hit_out(inr_hit[p]));
    clp_cmp #(.CW(CW), .ABOVE(1'b1)) u_ovr (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cur_in(cur_p), .thr_in(thr_over_in), .hit_out(ovr_hit[p]));
  end
  // phase conditions
  assign low = &low_hit;
  assign inr = &inr_hit;
  assign ovr = |ovr_hit;
  assign nrm = !low && !inr && !ovr;
  // pick-up state machine and its three timers, evaluated once per tick
  always_comb begin
    next_state = state;
    next_low_cnt = low_cnt;
    next_min_cnt = min_cnt;
    next_max_cnt = max_cnt;
    low_inc = inc(low_cnt);
    min_inc = inc(min_cnt);
    max_inc = inc(max_cnt);
    fire_act = 1'b0;
    fire_blk = 1'b0;
    if (tick_d) begin
      case (state)
        ST_NORM: begin
          if (!low) begin
            next_low_cnt = '0;
          end else if (low_inc >= t_start_in) begin
            fire_blk = blk_s;
            fire_act = !blk_s;
            next_state = blk_s ? ST_BLK : ST_ACT;
            next_min_cnt = '0;
            next_max_cnt = '0;
          end else begin
            next_low_cnt = low_inc;
          end
        end
        ST_ACT: begin
          next_min_cnt = min_inc;
          if (blk_s || ovr) begin
            next_state = ST_NORM;
            next_low_cnt = '0;
          end else if (inr) begin
            next_max_cnt = max_inc;
            if (max_inc >= t_max_in) begin
              next_state = ST_NORM;
              next_low_cnt = '0;
            end
          end else begin
            next_max_cnt = '0;
            if (min_inc >= t_min_in) begin
              next_state = ST_NORM;
              next_low_cnt = '0;
            end
          end
        end
        ST_BLK: begin
          if (!low || !blk_s) begin
            next_state = ST_NORM;
            next_low_cnt = '0;
          end
        end
        default: begin
          next_state = ST_NORM;
        end
      endcase
    end
    next_act = (next_state == ST_ACT);
    next_blkd = (next_state == ST_BLK);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_NORM;
      low_cnt <= '0;
      min_cnt <= '0;
      max_cnt <= '0;
      cold_load_active_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      min_cnt <= next_min_cnt;
      max_cnt <= next_max_cnt;
      cold_load_active_out <= next_act;
      blocked_out <= next_blkd;
    end
  end
  // edge events with ON/OFF selection and timestamp
  always_comb begin
    lv = '0;
    lv[EV_LOW] = low;
    lv[EV_INR] = inr;
    lv[EV_NRM] = nrm;
    lv[EV_OVR] = ovr;
    lv[EV_ACT] = cold_load_active_out;
    lv[EV_BLK] = blocked_out;
    next_ev_on = lv & ~lv_prev & ev_on_sel_in;
    next_ev_off = ~lv & lv_prev & ev_off_sel_in;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lv_prev <= NEV'(1) << EV_NRM; // load is normal at rest, no false ON after reset
      cold_load_event_block_on_out <= '0;
      cold_load_event_block_off_out <= '0;
      ev_time_out <= '0;
    end else begin
      lv_prev <= lv;
      cold_load_event_block_on_out <= next_ev_on;
      cold_load_event_block_off_out <= next_ev_off;
      ev_time_out <= ms_time;
    end
  end
  // cumulative counters, a count in the clearing cycle survives
  always_comb begin
    next_act_cnt = cnt_clear_in ? 16'h0000 : act_count_out;
    next_blk_cnt = cnt_clear_in ? 16'h0000 : blk_count_out;
    if (fire_act) begin
      next_act_cnt = 16'(next_act_cnt + 1'b1);
    end
    if (fire_blk) begin
      next_blk_cnt = 16'(next_blk_cnt + 1'b1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      act_count_out <= 16'h0000;
      blk_count_out <= 16'h0000;
    end else begin
      act_count_out <= next_act_cnt;
      blk_count_out <= next_blk_cnt;
    end
  end
  // operation log: record build, write pointer, newest-first read
  always_comb begin
    wr_rec.stamp = ms_time;
    wr_rec.event_id = fire_act ? 3'(EV_ACT) : 3'(EV_BLK);
    wr_rec.i1 = cur1;
    wr_rec.i2 = cur2;
    wr_rec.i3 = cur3;
    wr_rec.to_act = (t_start_in > low_cnt) ? TW'(t_start_in - low_cnt) : '0;
    wr_rec.act_time = min_cnt;
    wr_rec.startup = max_cnt;
    wr_rec.reclaim = (t_min_in > min_cnt) ? TW'(t_min_in - min_cnt) : '0;
    wr_rec.group = group_in;
    next_wr_ptr = wr_ptr;
    next_log_cnt = log_count_out;
    if (fire_act || fire_blk) begin
      next_wr_ptr = (wr_ptr == LOG_LAST) ? '0 : LPW'(wr_ptr + 1'b1);
      next_log_cnt = (log_count_out == LPW'(LOG_DEPTH)) ?
                     log_count_out : LPW'(log_count_out + 1'b1);
    end
    rd_sum = (LPW+1)'(wr_ptr) + (LPW+1)'(LOG_LAST) - (LPW+1)'(log_idx_in);
    rd_idx = (rd_sum >= (LPW+1)'(LOG_DEPTH)) ?
             LPW'(rd_sum - (LPW+1)'(LOG_DEPTH)) : LPW'(rd_sum);
    next_log_valid = (log_idx_in < log_count_out);
    next_rd_rec = next_log_valid ? log_mem[rd_idx] : '0;
  end
  always_ff @(posedge clk_in) begin
    if (fire_act || fire_blk) begin
      log_mem[wr_ptr] <= wr_rec;
    end
    if (!rst_n_in) begin
      wr_ptr <= '0;
      log_count_out <= '0;
      log_valid_out <= 1'b0;
      rd_rec <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      log_count_out <= next_log_cnt;
      log_valid_out <= next_log_valid;
      rd_rec <= next_rd_rec;
    end
  end
  // record fields out of the read register, in record order
  assign {log_time_out, log_event_out, log_i1_out, log_i2_out, log_i3_out, log_to_act_out,
          log_act_time_out, log_startup_out, log_reclaim_out, log_group_out} = rd_rec;
  // checks on the pick-up behaviour, block sampling and log fill
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_pickup;
    tick_d && state == ST_NORM && low && low_inc >= t_start_in;
  endsequence
  sequence s_active_tick;
    tick_d && state == ST_ACT && !blk_s && !ovr;
  endsequence
  a_block_sampled: assert property ($changed(blk_s) |-> $past(tick))
    else $error("block sample moved outside a program cycle");
  a_pickup_active: assert property (s_pickup ##0 !blk_s |=> cold_load_active_out
    ##0 act_count_out == $past(act_count_out) + 16'h0001 || $past(cnt_clear_in))
    else $error("unblocked pick-up did not activate and count");
  a_pickup_blocked: assert property (s_pickup ##0 blk_s |=>
    blocked_out && !cold_load_active_out)
    else $error("blocked pick-up did not give blocked indication");
  a_block_drops: assert property (tick_d && state == ST_ACT && blk_s |=>
    !cold_load_active_out [*2])
    else $error("blocking did not drop active output");
  a_needs_low: assert property ($rose(cold_load_active_out) |-> $past(low)
    && $past(low_inc) >= $past(t_start_in))
    else $error("activated without low current for start time");
  a_over_drop: assert property (tick_d && state == ST_ACT && ovr |=>
    !cold_load_active_out)
    else $error("overcurrent did not release output");
  a_max_expiry: assert property (s_active_tick ##0 inr && max_inc >= t_max_in
    |=> !cold_load_active_out)
    else $error("maximum timer expiry did not release");
  a_min_hold: assert property (s_active_tick ##0 min_inc < t_min_in
    && !(inr && max_inc >= t_max_in) |=> cold_load_active_out)
    else $error("output released before minimum time");
  a_log_fill: assert property ((fire_act || fire_blk) && log_count_out < 4'hC
    |=> log_count_out == $past(log_count_out) + 4'h1)
    else $error("log count did not advance on a record");
endmodule
